// >>> sfc_consts.vh
// Purpose: constants for the serial flash command and status logic
// Assumes: 40 MHz core clock, serial clock sampled as an ordinary input
// Notes:   opcodes, status bit positions, reset values and busy times
// How it works
// - 20h small wipe, D8h large wipe, 02h page write; three address bytes, msb first
// - whole array wipe decodes from 60h or C7h, with no address bytes
// - 38h quad page write, ADh auto increment write, both carry an address
// - B9h sleeps, ABh wakes; with three dummy bytes it returns a signature byte
// - 90h, EFh, DFh id pair reads on one, two, four lines after three bytes
// - id pair address 00h gives maker code first, 01h device code first
// - dual transfers count address in 2-bit units, msb of a pair on io_line1
// - 06h sets the write latch, 04h clears it, each a lone opcode frame
// - latch clears at reset and when clear, status write, program or wipe ends, except in auto increment mode
// - id read returns 24 bits: maker, memory type, device; may stop anytime
// - id read is not decoded while busy; running work is untouched
// - status read is always accepted and repeats the status byte while selected
// - busy flag is 1 while program, erase or status write runs, else 0
// - with latch at 0, program, erase and status write are refused
// - program or erase to a protected region is ignored, latch unchanged
// - protect level blocks program and wipe; whole wipe only when level is 0
// - quad enable defaults to 0; 1 lets 38h and DFh use four data lines, protect pin still honoured
// - status lock 1 with protect pin low rejects status write
// - opcode 06h is latch set, 04h is latch clear
// - write class commands run only if select rises on a byte boundary, or for ABh once its signature output has begun
// - status bit 1 is the latch, bit 0 busy; status write keeps both
`ifndef SFC_CONSTS_VH
`define SFC_CONSTS_VH
`define SFC_OP_LSET    8'h06
`define SFC_OP_LCLR    8'h04
`define SFC_OP_IDRD    8'h9F
`define SFC_OP_SRD     8'h05
`define SFC_OP_SWR     8'h01
`define SFC_OP_QPW     8'h38
`define SFC_OP_SWIPE   8'h20
`define SFC_OP_LWIPE   8'hD8
`define SFC_OP_AWIPE1  8'h60
`define SFC_OP_AWIPE2  8'hC7
`define SFC_OP_PW      8'h02
`define SFC_OP_AIW     8'hAD
`define SFC_OP_SLEEP   8'hB9
`define SFC_OP_WAKE    8'hAB
`define SFC_OP_IDP1    8'h90
`define SFC_OP_IDP2    8'hEF
`define SFC_OP_IDP4    8'hDF
`define SFC_OP_OTPIN   8'hB1
`define SFC_OP_OTPOUT  8'hC1
`define SFC_OP_SECRD   8'h2B
`define SFC_OP_SECWR   8'h2F
`define SFC_OP_RBON    8'h70
`define SFC_OP_RBOFF   8'h80
`define SFC_ST_BUSY    0
`define SFC_ST_LATCH   1
`define SFC_ST_PL_LO   2
`define SFC_ST_QE      6
`define SFC_ST_LOCK    7
`define SFC_SEC_LOCK   1
`define SFC_NV_RESET   6'h00
`define SFC_CLK_NS     25
`define SFC_BUSY_US    10
`define SFC_BUSY_CYC   16'h0190
`endif

// >>> sfc_cmd_status.v
// Purpose: command decoder, write latch and status register of a serial flash
// Assumes: serial clock, select and data pins sampled by i_clk through three flops
// Notes:   array datapaths are outside; busy time is a stand-in parameter
`timescale 1ns/1ps
`default_nettype none
`include "sfc_consts.vh"

module sfc_cmd_status #(
  parameter [15:0] BUSY_CYCLES = `SFC_BUSY_CYC,
  parameter [7:0]  MAKER_CODE  = 8'h5A,
  parameter [7:0]  MEM_TYPE    = 8'h3C,
  parameter [7:0]  DEV_CODE    = 8'h17,
  parameter [7:0]  SIG_CODE    = 8'h16
) (
  // clock and reset
  input  wire        i_clk,
  input  wire        i_arst_n,
  // serial pins
  input  wire        i_cs_n,
  input  wire        i_sclk,
  input  wire [3:0]  i_io,
  input  wire        i_protect_pin_n,
  output reg  [3:0]  o_io,
  output reg  [3:0]  o_io_oe,
  // array side
  output reg  [23:0] o_addr,
  output reg  [7:0]  o_op,
  output reg         o_op_start,
  output reg         o_sleep,
  output reg         o_otp_mode,
  output reg  [7:0]  o_status
);

  // ---------------------------------------------------------------
  // reset release and pin sampling
  // ---------------------------------------------------------------
  reg  [1:0] rst_sync;
  wire       rst_n = rst_sync[1];
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) rst_sync <= 2'h0;
    else rst_sync <= {rst_sync[0], 1'b1};
  end

  reg [6:0] s1, s2, s3;
  reg [6:0] pin;
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1  <= 7'h41;
      s2  <= 7'h41;
      s3  <= 7'h41;
      pin <= 7'h41;
    end else begin
      s1 <= {i_protect_pin_n, i_io, i_sclk, i_cs_n};
      s2 <= s1;
      s3 <= s2;
      pin <= (pin & (s2 ^ s3)) | (s2 & ~(s2 ^ s3));
    end
  end
  wire       cs_n   = pin[0];
  wire       sclk   = pin[1];
  wire [3:0] din    = pin[5:2];
  wire       wp_n   = pin[6];
  reg        sclk_d;
  reg        cs_d;
  wire       rise   = sclk & ~sclk_d & ~cs_n;
  wire       fall   = ~sclk & sclk_d & ~cs_n;
  wire       cs_up  = cs_n & ~cs_d;

  // ---------------------------------------------------------------
  // status and mode state
  // ---------------------------------------------------------------
  reg        latch;
  reg        busy;
  reg [3:0]  plevel;
  reg        quad_on;
  reg        slock;
  reg        sec_lock;
  reg        rb_on;
  reg        aiw_mode;
  reg [15:0] busy_cnt;
  wire [7:0] status = {slock, quad_on, plevel, latch, busy};

  // ---------------------------------------------------------------
  // frame shifting
  // ---------------------------------------------------------------
  reg [7:0]  shreg;
  reg [2:0]  bitc;
  reg [3:0]  bytec;
  reg [7:0]  op;
  reg [23:0] addr;
  reg [7:0]  data1;
  reg [7:0]  idsel;
  reg [1:0]  width;
  reg [23:0] oshift;
  reg        oact;
  reg        ignore;

  // bits per serial edge for each opcode after the first byte
  function [1:0] lane_width;
    input [7:0] c;
    begin
      case (c)
        `SFC_OP_IDP2: lane_width = 2'h1;
        `SFC_OP_IDP4, `SFC_OP_QPW: lane_width = 2'h2;
        default: lane_width = 2'h0;
      endcase
    end
  endfunction

  // write class: must end on a byte boundary, except ABh once its signature output has begun
  function is_write_class;
    input [7:0] c;
    begin
      case (c)
        `SFC_OP_LSET, `SFC_OP_LCLR, `SFC_OP_SWR, `SFC_OP_SWIPE, `SFC_OP_LWIPE,
        `SFC_OP_AWIPE1, `SFC_OP_AWIPE2, `SFC_OP_PW, `SFC_OP_QPW, `SFC_OP_AIW,
        `SFC_OP_SLEEP, `SFC_OP_WAKE, `SFC_OP_OTPIN, `SFC_OP_OTPOUT,
        `SFC_OP_SECWR: is_write_class = 1'b1;
        default: is_write_class = 1'b0;
      endcase
    end
  endfunction

  // simple protected range: top 2^(level-1) of 64 blocks, none at level 0, all 64 from level 7 up
  function prot_hit;
    input [3:0]  lvl;
    input [23:0] a;
    reg   [6:0]  blocks;
    begin
      blocks = (lvl == 4'h0) ? 7'h00 : ((lvl > 4'h7) ? 7'h40 : (7'h01 << (lvl - 4'h1)));
      prot_hit = ({1'b0, a[21:16]} >= (7'h40 - blocks));
    end
  endfunction

  wire [3:0] sin_bits = (width == 2'h2) ? din :
                        (width == 2'h1) ? {2'h0, din[1:0]} : {3'h0, din[0]};
  wire       byte_end = (width == 2'h2) ? (bitc == 3'h4) :
                        (width == 2'h1) ? (bitc == 3'h6) : (bitc == 3'h7);
  wire [7:0] next_shreg = (width == 2'h2) ? {shreg[3:0], sin_bits} :
                          (width == 2'h1) ? {shreg[5:0], din[1], din[0]} :
                                            {shreg[6:0], din[0]};
  wire [2:0] step = (width == 2'h2) ? 3'h4 : ((width == 2'h1) ? 3'h2 : 3'h1);

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
      shreg <= 8'h00;
      bitc <= 3'h0;
      bytec <= 4'h0;
      op <= 8'h00;
      addr <= 24'h000000;
      data1 <= 8'h00;
      idsel <= 8'h00;
      width <= 2'h0;
      oshift <= 24'h000000;
      oact <= 1'b0;
      ignore <= 1'b0;
      latch <= 1'b0;
      busy <= 1'b0;
      busy_cnt <= 16'h0000;
      plevel <= 4'h0;
      quad_on <= 1'b0;
      slock <= 1'b0;
      sec_lock <= 1'b0;
      rb_on <= 1'b0;
      aiw_mode <= 1'b0;
      o_io <= 4'h0;
      o_io_oe <= 4'h0;
      o_addr <= 24'h000000;
      o_op <= 8'h00;
      o_op_start <= 1'b0;
      o_sleep <= 1'b0;
      o_otp_mode <= 1'b0;
      o_status <= 8'h00;
    end else begin
      sclk_d <= sclk;
      cs_d <= cs_n;
      o_op_start <= 1'b0;
      o_status <= status;
      if (busy) begin
        if (busy_cnt == 16'h0001) begin
          busy <= 1'b0;
          if (!aiw_mode) latch <= 1'b0;
        end
        busy_cnt <= busy_cnt - 16'h0001;
      end
      if (cs_n) begin
        bitc <= 3'h0;
        bytec <= 4'h0;
        width <= 2'h0;
        oact <= 1'b0;
        ignore <= 1'b0;
        o_io_oe <= 4'h0;
        if (aiw_mode && rb_on) begin
          o_io_oe <= 4'h2;
          o_io <= {2'h0, ~busy, 1'b0};
        end
      end
      if (rise && !ignore && !oact) begin
        shreg <= next_shreg;
        bitc <= bitc + step;
        if (byte_end) begin
          bitc <= 3'h0;
          if (bytec != 4'hF) bytec <= bytec + 4'h1;
          if (bytec == 4'h0) begin
            op <= next_shreg;
            width <= lane_width(next_shreg);
            if (next_shreg == `SFC_OP_IDRD) begin
              if (busy) ignore <= 1'b1;
              else begin
                oact <= 1'b1;
                oshift <= {MAKER_CODE, MEM_TYPE, DEV_CODE};
              end
            end
            if (next_shreg == `SFC_OP_SRD) begin
              oact <= 1'b1;
              oshift <= {status, status, status};
            end
            if (next_shreg == `SFC_OP_SECRD) begin
              oact <= 1'b1;
              oshift <= {6'h00, sec_lock, o_otp_mode, 16'h0000};
            end
          end else if (bytec <= 4'h3) begin
            addr <= {addr[15:0], next_shreg};
            if (bytec == 4'h1) data1 <= next_shreg;
            if (bytec == 4'h3 && op == `SFC_OP_WAKE) begin
              oact <= 1'b1;
              oshift <= {SIG_CODE, SIG_CODE, SIG_CODE};
            end
            // id pair after two dummies and address
            if (bytec == 4'h3 && (op == `SFC_OP_IDP1 || op == `SFC_OP_IDP2 ||
                op == `SFC_OP_IDP4)) begin
              oact <= 1'b1;
              idsel <= next_shreg;
              oshift <= next_shreg[0] ? {DEV_CODE, MAKER_CODE, DEV_CODE} :
                                        {MAKER_CODE, DEV_CODE, MAKER_CODE};
            end
          end
        end
      end
      // output shifting on falling serial edge
      if (fall && oact) begin
        if (width == 2'h0 || op == `SFC_OP_SRD || op == `SFC_OP_IDRD) begin
          o_io_oe <= 4'h2;
          o_io <= {2'h0, oshift[23], 1'b0};
          oshift <= {oshift[22:0], (op == `SFC_OP_SRD) ? oshift[23] : 1'b0};
        end else if (width == 2'h1) begin
          o_io_oe <= 4'h3;
          o_io <= {2'h0, oshift[23:22]};
          oshift <= {oshift[21:0], 2'h0};
        end else begin
          o_io_oe <= 4'hF;
          o_io <= oshift[23:20];
          oshift <= {oshift[19:0], 4'h0};
        end
        if (op == `SFC_OP_SRD && bitc == 3'h7) oshift <= {status, status, status};
        bitc <= bitc + 3'h1;
      end
      // ---------------------------------------------------------------
      // execution at select rise
      // ---------------------------------------------------------------
      // only on byte boundary, or once output has begun
      if (cs_up && !ignore && (bitc == 3'h0 || oact) &&
          is_write_class(op) && bytec != 4'h0) begin
        case (op)
          `SFC_OP_LSET: if (bytec == 4'h1) latch <= 1'b1;
          `SFC_OP_LCLR: if (bytec == 4'h1) latch <= 1'b0;
          `SFC_OP_SWR: begin
            if (latch && !busy && bytec == 4'h2 && !(slock && !wp_n)) begin
              slock <= data1[`SFC_ST_LOCK];
              quad_on <= data1[`SFC_ST_QE];
              plevel <= data1[5:2];
              busy <= 1'b1;
              busy_cnt <= BUSY_CYCLES;
            end
          end
          `SFC_OP_AWIPE1, `SFC_OP_AWIPE2: begin
            if (latch && !busy && bytec == 4'h1 && plevel == 4'h0) begin
              o_op <= op;
              o_op_start <= 1'b1;
              busy <= 1'b1;
              busy_cnt <= BUSY_CYCLES;
            end
          end
          `SFC_OP_SWIPE, `SFC_OP_LWIPE, `SFC_OP_PW, `SFC_OP_QPW, `SFC_OP_AIW: begin
            if (latch && !busy && bytec >= 4'h4 && !prot_hit(plevel, addr)) begin
              o_op <= op;
              o_addr <= addr;
              o_op_start <= 1'b1;
              busy <= 1'b1;
              busy_cnt <= BUSY_CYCLES;
              if (op == `SFC_OP_AIW) aiw_mode <= 1'b1;
            end
          end
          `SFC_OP_SLEEP: if (bytec == 4'h1) o_sleep <= 1'b1;
          `SFC_OP_WAKE: o_sleep <= 1'b0;
          `SFC_OP_OTPIN: if (bytec == 4'h1) o_otp_mode <= 1'b1;
          `SFC_OP_OTPOUT: if (bytec == 4'h1) o_otp_mode <= 1'b0;
          `SFC_OP_SECWR: if (bytec == 4'h1 && !busy) sec_lock <= 1'b1;
          default: ;
        endcase
      end
      if (cs_up && bitc == 3'h0 && bytec == 4'h1) begin
        if (op == `SFC_OP_RBON) rb_on <= 1'b1;
        if (op == `SFC_OP_RBOFF) rb_on <= 1'b0;
        // auto increment ends on latch clear
        if (op == `SFC_OP_LCLR && aiw_mode) aiw_mode <= 1'b0;
      end
      if (!quad_on && width == 2'h2) width <= 2'h0;
    end
  end

endmodule
`default_nettype wire

// >>> sfc_cmd_status_sva.sv
// Purpose: port checker for sfc_cmd_status
// Assumes: o_status trails the internal bits by one cycle
// Notes:   bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
module sfc_cmd_status_sva #(
  parameter [15:0] BUSY_CYCLES = 16'h0190
) (
  // clock, reset, pins
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  input wire logic        i_cs_n,
  input wire logic        i_sclk,
  input wire logic [3:0]  i_io,
  input wire logic        i_protect_pin_n,
  // outputs
  input wire logic [3:0]  o_io,
  input wire logic [3:0]  o_io_oe,
  input wire logic [23:0] o_addr,
  input wire logic [7:0]  o_op,
  input wire logic        o_op_start,
  input wire logic        o_sleep,
  input wire logic        o_otp_mode,
  input wire logic [7:0]  o_status
);
  // ----------------
  // busy cycle count
  // ----------------
  logic [15:0] bcnt;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) bcnt <= 16'h0000;
    else bcnt <= o_status[0] ? bcnt + 16'h0001 : 16'h0000;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  a_start_latch: assert property (
    o_op_start |-> $past(o_status[1]) && !$past(o_status[0])) else $error("start without latch");
  a_start_cs_high: assert property (
    o_op_start |-> i_cs_n && $past(i_cs_n, 3)) else $error("start while selected");
  a_op_legal: assert property (
    o_op_start |-> o_op inside {8'h20, 8'hD8, 8'h02, 8'h38, 8'hAD, 8'h60, 8'hC7})
    else $error("bad opcode started");
  a_whole_unprot: assert property (
    o_op_start && (o_op == 8'h60 || o_op == 8'hC7) |-> $past(o_status[5:2]) == 4'h0)
    else $error("whole wipe while protected");
  a_start_busy: assert property (
    o_op_start |-> ##[1:4] o_status[0]) else $error("no busy after start");
  a_busy_time: assert property (
    $fell(o_status[0]) |-> $past(bcnt) >= BUSY_CYCLES - 3 && $past(bcnt) <= BUSY_CYCLES + 3)
    else $error("busy length wrong");
  a_latch_drops: assert property (
    $fell(o_status[0]) && o_op != 8'hAD |-> ##[0:2] !o_status[1]) else $error("latch kept");
  a_lock_holds: assert property (
    o_status[7] && !i_protect_pin_n && !$past(i_protect_pin_n, 8) |=> $stable(o_status[7:2]))
    else $error("locked status changed");
endmodule
bind sfc_cmd_status sfc_cmd_status_sva #(.BUSY_CYCLES(BUSY_CYCLES)) u_sva (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_cs_n(i_cs_n), .i_sclk(i_sclk), .i_io(i_io),
  .i_protect_pin_n(i_protect_pin_n), .o_io(o_io), .o_io_oe(o_io_oe), .o_addr(o_addr),
  .o_op(o_op), .o_op_start(o_op_start), .o_sleep(o_sleep), .o_otp_mode(o_otp_mode),
  .o_status(o_status));
`default_nettype wire

// >>> sfc_host_model.sv
// Purpose: host serial controller model for sfc_cmd_status
// Assumes: mode 0, 200 ns serial clock, still between frames
// Notes:   undriven lines toggle every core cycle
`timescale 1ns/1ps
`default_nettype none
module sfc_host_model (
  // core clock for the idle pattern
  input  wire logic       i_clk,
  // device pins
  input  wire logic [3:0] i_dev_io,
  input  wire logic [3:0] i_dev_oe,
  output var  logic       o_cs_n,
  output var  logic       o_sclk,
  output wire logic [3:0] o_io,
  // read results
  output var  logic [7:0] o_rd_byte,
  output var  logic [7:0] o_rd_cnt
);
  // -----------
  // line levels
  // -----------
  logic drv = 1'b0;
  logic d0 = 1'b0;
  logic tgl = 1'b0;
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_rd_byte = 8'h00;
    o_rd_cnt = 8'h00;
  end
  always @(posedge i_clk) tgl <= ~tgl;
  assign o_io[0] = i_dev_oe[0] ? i_dev_io[0] : (drv ? d0 : tgl);
  assign o_io[3:1] = (i_dev_oe[3:1] & i_dev_io[3:1]) | (~i_dev_oe[3:1] & {3{tgl}});
  task automatic xfer(input logic [7:0] op, input logic [23:0] a = 24'h0,
                      input int nt = 0, input int nr = 0, input int cut = 0);
    logic [31:0] v;
    logic [7:0]  sh;
    int          nb;
    v = {op, a};
    nb = 8 + 8 * (nt + nr) - cut;
    o_cs_n = 1'b0;
    drv = 1'b1;
    #100;
    for (int b = 0; b < nb; b++) begin
      o_sclk = 1'b0;
      d0 = (b < 32) ? v[31 - b] : 1'b0;
      #100;
      o_sclk = 1'b1;
      #100;
      sh = {sh[6:0], o_io[1]};
      if (b >= 8 * (nt + 1) && b % 8 == 7) begin
        o_rd_byte = sh;
        o_rd_cnt = o_rd_cnt + 8'h01;
      end
    end
    o_sclk = 1'b0;
    #100;
    o_cs_n = 1'b1;
    drv = 1'b0;
    #400;
  endtask
endmodule
`default_nettype wire

// >>> sfc_cmd_status_tb_top.sv
// Purpose: self-checking bench for sfc_cmd_status
// Assumes: host model frames every command
// Notes:   busy of 400 cycles leaves room for a status read
`timescale 1ns/1ps
`default_nettype none
module sfc_cmd_status_tb_top;
  // identity values, arbitrary
  localparam logic [7:0] MK = 8'hA6;
  localparam logic [7:0] MT = 8'h4D;
  localparam logic [7:0] DV = 8'h3B;
  localparam logic [7:0] SG = 8'h29;
  localparam logic [7:0] OPS [6] = '{8'h20, 8'hD8, 8'h02, 8'h38, 8'h60, 8'hC7};
  logic        i_clk;
  logic        i_arst_n;
  logic        i_protect_pin_n;
  wire         cs_n;
  wire         sclk;
  wire  [3:0]  io;
  wire  [3:0]  o_io;
  wire  [3:0]  o_io_oe;
  wire  [23:0] o_addr;
  wire  [7:0]  o_op;
  wire         o_op_start;
  wire         o_sleep;
  wire         o_otp_mode;
  wire  [7:0]  o_status;
  wire  [7:0]  rd_byte;
  wire  [7:0]  rd_cnt;
  int          n_errors;
  int          comparisons;
  logic [31:0] seed;
  logic [32:0] e;
  logic [7:0]  rq[$];
  logic [32:0] oq[$];
  // ---------
  // instances
  // ---------
  sfc_cmd_status #(.BUSY_CYCLES(16'h0190), .MAKER_CODE(MK), .MEM_TYPE(MT),
    .DEV_CODE(DV), .SIG_CODE(SG)) DUT (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_cs_n(cs_n), .i_sclk(sclk), .i_io(io), .i_protect_pin_n(i_protect_pin_n),
    .o_io(o_io), .o_io_oe(o_io_oe), .o_addr(o_addr), .o_op(o_op),
    .o_op_start(o_op_start), .o_sleep(o_sleep), .o_otp_mode(o_otp_mode),
    .o_status(o_status));
  sfc_host_model hm (.i_clk(i_clk), .i_dev_io(o_io), .i_dev_oe(o_io_oe), .o_cs_n(cs_n),
    .o_sclk(sclk), .o_io(io), .o_rd_byte(rd_byte), .o_rd_cnt(rd_cnt));
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic st(input logic [7:0] x);
    rq.push_back(x);
    hm.xfer(8'h05, 24'h0, 0, 1);
  endtask
  task automatic results;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // --------
  // watchers
  // --------
  always @(rd_cnt) begin
    if (rq.size() != 0) chk("read", rd_byte, rq.pop_front());
  end
  always @(negedge i_clk) begin
    if (o_op_start === 1'b1) begin
      if (oq.size() == 0) chk("start", 1, 0);
      else begin
        e = oq.pop_front();
        chk("op", o_op, e[31:24]);
        if (e[32]) chk("addr", o_addr, e[23:0]);
      end
    end
  end
  initial begin
    #1000000;
    n_errors++;
    results;
  end
  initial begin
    i_arst_n = 1'b0;
    i_protect_pin_n = 1'b1;
    n_errors = 0;
    comparisons = 0;
    seed = 32'h00001C4F;
    repeat (5) @(posedge i_clk);
    #7 i_arst_n = 1'b1;
    repeat (10) @(posedge i_clk);
    #7;
    rq.push_back(8'h00);
    rq.push_back(8'h00);
    hm.xfer(8'h05, 24'h0, 0, 2);
    hm.xfer(8'h06);
    st(8'h02);
    hm.xfer(8'h04);
    st(8'h00);
    hm.xfer(8'h06);
    hm.xfer(8'h04, 24'h0, 0, 0, 1);
    st(8'h02);
    hm.xfer(8'h04);
    seed = xs(seed);
    hm.xfer(8'h02, seed[23:0], 3);
    st(8'h00);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      hm.xfer(8'h06);
      oq.push_back({i < 4, OPS[i], seed[23:0]});
      hm.xfer(OPS[i], seed[23:0], i < 4 ? 3 : 0);
      st(8'h03);
      #12000;
      st(8'h00);
    end
    hm.xfer(8'h70);
    hm.xfer(8'h06);
    seed = xs(seed);
    oq.push_back({1'b1, 8'hAD, seed[23:0]});
    hm.xfer(8'hAD, seed[23:0], 3);
    chk("rb_oe", o_io_oe, 4'h2);
    chk("rb", o_io[1], 0);
    #12000;
    chk("rb", o_io[1], 1);
    st(8'h02);
    hm.xfer(8'h04);
    hm.xfer(8'h80);
    st(8'h00);
    chk("rb_oe", o_io_oe, 4'h0);
    hm.xfer(8'h06);
    hm.xfer(8'h01, 24'h3C0000, 1);
    #12000;
    st(8'h3C);
    hm.xfer(8'h06);
    hm.xfer(8'h02, 24'hFF0000, 3);
    hm.xfer(8'h60);
    st(8'h3E);
    hm.xfer(8'h01, 24'hBC0000, 1);
    #12000;
    st(8'hBC);
    chk("status", o_status, 8'hBC);
    @(posedge i_clk);
    #7 i_protect_pin_n = 1'b0;
    hm.xfer(8'h06);
    hm.xfer(8'h01, 24'h0, 1);
    #12000;
    hm.xfer(8'h04);
    st(8'hBC);
    @(posedge i_clk);
    #7 i_protect_pin_n = 1'b1;
    hm.xfer(8'h06);
    hm.xfer(8'h01, 24'h0, 1);
    #12000;
    st(8'h00);
    rq.push_back(MK);
    rq.push_back(MT);
    rq.push_back(DV);
    hm.xfer(8'h9F, 24'h0, 0, 3);
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      rq.push_back(k[0] ? DV : MK);
      rq.push_back(k[0] ? MK : DV);
      hm.xfer(k[1] ? 8'hDF : 8'h90, {seed[23:8], 7'h00, k[0]}, 3, 2);
    end
    hm.xfer(8'hB9);
    chk("sleep", o_sleep, 1);
    seed = xs(seed);
    rq.push_back(SG);
    hm.xfer(8'hAB, seed[23:0], 3, 1);
    chk("wake", o_sleep, 0);
    hm.xfer(8'hB1);
    chk("otp", o_otp_mode, 1);
    rq.push_back(8'h01);
    hm.xfer(8'h2B, 24'h0, 0, 1);
    hm.xfer(8'h2F);
    rq.push_back(8'h03);
    hm.xfer(8'h2B, 24'h0, 0, 1);
    hm.xfer(8'hC1);
    chk("otp", o_otp_mode, 0);
    rq.push_back(8'h02);
    hm.xfer(8'h2B, 24'h0, 0, 1);
    #1000;
    chk("starts", oq.size(), 0);
    chk("reads", rq.size(), 0);
    results;
  end
endmodule
`default_nettype wire
